// File: dv/ohc_chk_checker.sv
`timescale 1ns/1ns
module ohc_chk (input wire logic clk_in, rst_in, monitor_in,
	input wire logic restart_in, clear_all_in, restore_in, flag_out,
	input wire logic hour_tick_out,
	input wire logic [13:0] service_interval_in, hours_remaining_out,
	input wire logic [16:0] accumulated_hours_out);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_rld; restart_in |=> !flag_out && hours_remaining_out ==
		(($past(service_interval_in) > 14'h270F) ? 14'h270F
		: $past(service_interval_in)); endproperty
	a_rld: assert property (p_rld) else $error("reload");
	property p_clr; clear_all_in |=> accumulated_hours_out == 0; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_hld; restart_in && !clear_all_in && !restore_in
		|=> $stable(accumulated_hours_out); endproperty
	a_hld: assert property (p_hld) else $error("total kept");
	property p_flg; hours_remaining_out == 0 && !restart_in &&
		!clear_all_in |=> flag_out; endproperty
	a_flg: assert property (p_flg) else $error("flag");
	property p_stp; restart_in || clear_all_in || !monitor_in
		|-> !hour_tick_out; endproperty
	a_stp: assert property (p_stp) else $error("tick");
	property p_sat; accumulated_hours_out == 17'h1_869F && !clear_all_in
		&& !restore_in |=> $stable(accumulated_hours_out); endproperty
	a_sat: assert property (p_sat) else $error("saturate");
endmodule : ohc_chk
bind ohc_counter ohc_chk u_chk (.*);

// File: dv/ohc_prog.sv
`timescale 1ns/1ns
module ohc_prog (input wire logic [2:0] cmd_in,
	output logic mon_out, rst_out, clr_out);
	assign {mon_out, rst_out, clr_out} = cmd_in;
endmodule : ohc_prog

// File: dv/test_operating_hours_counter.sv
`timescale 1ns/1ns
module test_operating_hours_counter;
	logic clk_in = 0, rst_in = 1, restore_in = 0, flag_out, hour_tick_out;
	logic monitor_in, restart_in, clear_all_in;
	logic [2:0] cmd = 3'h2;
	logic [13:0] service_interval_in = 14'h0003, hours_remaining_out;
	logic [16:0] restore_total_in = 17'h1_869E, accumulated_hours_out;
	int n_mismatch = 0, tests_run = 0;
	ohc_counter #(.HOUR_CYCLES(4)) dut (.*);
	ohc_prog prog (.cmd_in(cmd), .mon_out(monitor_in),
		.rst_out(restart_in), .clr_out(clear_all_in));
	initial forever #25 clk_in = ~clk_in;
	task automatic step(input logic [2:0] c, input int n, logic [31:0] e);
		cmd = c;
		repeat (n) @(negedge clk_in);
		tests_run++;
		if ({flag_out, hours_remaining_out, accumulated_hours_out} !== e)
		begin
			n_mismatch++;
			$display("mismatch %0t got %h", $time,
				{flag_out, hours_remaining_out, accumulated_hours_out});
		end
	endtask : step
	task automatic finish_test;
		$display("runs %0d errors %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test
	initial begin #20000 n_mismatch++; finish_test; end
	initial
	begin
		repeat (10) @(negedge clk_in);
		rst_in = 0;
		step(3'h2, 1, {1'b0, 14'h0003, 17'h0_0000});
		step(3'h4, 13, {1'b1, 14'h0000, 17'h0_0003});
		step(3'h6, 1, {1'b0, 14'h0003, 17'h0_0003});
		step(3'h5, 1, {1'b0, 14'h0003, 17'h0_0000});
		restore_in = 1;
		step(3'h0, 1, {1'b0, 14'h0003, 17'h1_869E});
		restore_in = 0;
		step(3'h4, 8, {1'b0, 14'h0001, 17'h1_869F});
		service_interval_in = 14'h270F;
		step(3'h7, 1, {1'b0, 14'h270F, 17'h0_0000});
		service_interval_in = 14'h3FFF;
		step(3'h2, 1, {1'b0, 14'h270F, 17'h0_0000});
		service_interval_in = 14'h0000;
		step(3'h2, 1, {1'b0, 14'h0000, 17'h0_0000});
		step(3'h0, 1, {1'b1, 14'h0000, 17'h0_0000});
		finish_test;
	end
endmodule : test_operating_hours_counter

// File: src/ohc_counter.sv
`timescale 1ns/1ns
module ohc_counter #(
	parameter longint HOUR_CYCLES = ohc_pkg::HOUR_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Function block inputs
	input  wire logic        monitor_in,
	input  wire logic        restart_in,
	input  wire logic        clear_all_in,
	input  wire logic [13:0] service_interval_in,
	// Retentive total restored after power-up
	input  wire logic        restore_in,
	input  wire logic [16:0] restore_total_in,
	// Results
	output logic             flag_out,
	output logic [13:0]      hours_remaining_out,
	output logic [16:0]      accumulated_hours_out,
	output logic             hour_tick_out
);
	// Prescaler geometry
	localparam int               PRE_W    = $clog2(HOUR_CYCLES);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(HOUR_CYCLES - 1);
	localparam logic [PRE_W-1:0] PRE_ZERO = '0;

	// Count widths follow the package
	localparam int REM_W = ohc_pkg::INTERVAL_W;
	localparam int TOT_W = ohc_pkg::TOTAL_W;

	// What happens to the remaining count at the next edge
	typedef enum logic [1:0]
	{
		REM_HOLD   = 2'h0,
		REM_RELOAD = 2'h1,
		REM_STEP   = 2'h3
	} ohc_remain_op_e;

	// What happens to the total at the next edge
	typedef enum logic [1:0]
	{
		TOT_HOLD    = 2'h0,
		TOT_CLEAR   = 2'h1,
		TOT_RESTORE = 2'h3,
		TOT_STEP    = 2'h2
	} ohc_total_op_e;

	// Out-of-range settings clip to the top of the legal range
	function automatic logic [REM_W-1:0] clip_interval
	(
		input logic [REM_W-1:0] value
	);
		logic [REM_W-1:0] result;
		result = value;
		if (value > ohc_pkg::INTERVAL_MAX)
		begin
			result = ohc_pkg::INTERVAL_MAX;
		end
		return result;
	endfunction : clip_interval

	// Step remaining down by one hour, never below zero
	function automatic logic [REM_W-1:0] dec_floor
	(
		input logic [REM_W-1:0] value
	);
		logic [REM_W-1:0] result;
		result = value;
		if (value != ohc_pkg::REMAIN_RESET)
		begin
			result = REM_W'(value - 1'b1);
		end
		return result;
	endfunction : dec_floor

	// Step the total up by one hour, never past the limit
	function automatic logic [TOT_W-1:0] inc_sat
	(
		input logic [TOT_W-1:0] value
	);
		logic [TOT_W-1:0] result;
		result = value;
		if (value != ohc_pkg::TOTAL_MAX)
		begin
			result = TOT_W'(value + 1'b1);
		end
		return result;
	endfunction : inc_sat

	// Either reset input reloads the interval
	function automatic logic reload_req
	(
		input logic restart,
		input logic clear
	);
		return restart | clear;
	endfunction : reload_req

	// Time only runs with the monitor high and both resets low
	function automatic logic counting_on
	(
		input logic monitor,
		input logic restart,
		input logic clear
	);
		return monitor & ~reload_req(restart, clear);
	endfunction : counting_on

	// A reload outranks an hour landing in the same cycle
	function automatic ohc_remain_op_e decode_remain_op
	(
		input logic reload_now,
		input logic step
	);
		ohc_remain_op_e op;
		op = REM_HOLD;
		if (reload_now)
		begin
			op = REM_RELOAD;
		end
		else if (step)
		begin
			op = REM_STEP;
		end
		return op;
	endfunction : decode_remain_op

	// Clear outranks restore, and both outrank a counted hour
	function automatic ohc_total_op_e decode_total_op
	(
		input logic clear,
		input logic restore,
		input logic step
	);
		ohc_total_op_e op;
		op = TOT_HOLD;
		if (clear)
		begin
			op = TOT_CLEAR;
		end
		else if (restore)
		begin
			op = TOT_RESTORE;
		end
		else if (step)
		begin
			op = TOT_STEP;
		end
		return op;
	endfunction : decode_total_op

	logic [PRE_W-1:0] prescale;
	logic [PRE_W-1:0] next_prescale;
	logic [REM_W-1:0] interval_clip;
	logic [REM_W-1:0] next_remaining;
	logic [TOT_W-1:0] next_total;
	logic             next_flag;
	logic             counting;
	logic             reload;
	logic             tick;
	ohc_remain_op_e   remain_op;
	ohc_total_op_e    total_op;

	assign interval_clip = clip_interval(service_interval_in);
	assign counting      = counting_on(monitor_in, restart_in,
		clear_all_in);
	assign reload        = reload_req(restart_in, clear_all_in);
	assign tick          = counting && (prescale == PRE_LAST);
	assign hour_tick_out = tick;
	assign remain_op     = decode_remain_op(reload, tick);
	assign total_op      = decode_total_op(clear_all_in, restore_in, tick);

	// Partial hours are kept across pauses so short runs still add up
	always_comb
	begin
		next_prescale = prescale;
		if (clear_all_in)
		begin
			next_prescale = PRE_ZERO;
		end
		else if (tick)
		begin
			next_prescale = PRE_ZERO;
		end
		else if (counting)
		begin
			next_prescale = PRE_W'(prescale + 1'b1);
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			prescale <= PRE_ZERO;
		end
		else
		begin
			prescale <= next_prescale;
		end
	end

	always_comb
	begin
		next_remaining = hours_remaining_out;
		case (remain_op)
			REM_RELOAD:
			begin
				next_remaining = interval_clip;
			end
			REM_STEP:
			begin
				next_remaining = dec_floor(hours_remaining_out);
			end
			default:
			begin
				next_remaining = hours_remaining_out;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			hours_remaining_out <= ohc_pkg::REMAIN_RESET;
		end
		else
		begin
			hours_remaining_out <= next_remaining;
		end
	end

	// Totals survive power loss only if the owner restores them
	always_comb
	begin
		next_total = accumulated_hours_out;
		case (total_op)
			TOT_CLEAR:
			begin
				next_total = ohc_pkg::TOTAL_RESET;
			end
			TOT_RESTORE:
			begin
				next_total = restore_total_in;
			end
			TOT_STEP:
			begin
				next_total = inc_sat(accumulated_hours_out);
			end
			default:
			begin
				next_total = accumulated_hours_out;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			accumulated_hours_out <= ohc_pkg::TOTAL_RESET;
		end
		else
		begin
			accumulated_hours_out <= next_total;
		end
	end

	// Sticky until a reload; a zero interval raises it one edge later
	always_comb
	begin
		next_flag = flag_out;
		if (reload)
		begin
			next_flag = 1'b0;
		end
		else if (next_remaining == ohc_pkg::REMAIN_RESET)
		begin
			next_flag = 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			flag_out <= 1'b0;
		end
		else
		begin
			flag_out <= next_flag;
		end
	end

	// Counts are plain outputs, readable at any time
endmodule : ohc_counter

// File: src/ohc_pkg.sv
// Functional notes
// - Monitor high and no reset: accumulate run time, count hours remaining down.
// - Output flag goes high once hours remaining reaches zero.
// - Interval restart high halts counting; resume only with both resets low.
// - Interval restart clears flag, reloads remaining from interval, keeps total.
// - Full clear high keeps the counter stopped, no time accumulates.
// - Full clear clears flag, reloads remaining, zeroes accumulated total.
// - Service interval in whole hours, accepted range zero to 9999.
// - Accumulated total saturates at 99999 hours and stops counting.
// - Accumulated total kept retentive across power loss; rst_in zeroes it, restore_in reloads it.
// - Remaining and total readable while running, no password needed.
package ohc_pkg;
	localparam int          CLK_HZ        = 20_000_000;
	localparam int          HOUR_S        = 3600;
	localparam longint      HOUR_CYCLES   = longint'(CLK_HZ) * HOUR_S;
	localparam int          INTERVAL_W    = 14;
	localparam int          TOTAL_W       = 17;
	localparam logic [13:0] INTERVAL_MAX  = 14'h270F;
	localparam logic [16:0] TOTAL_MAX     = 17'h1_869F;
	localparam logic [13:0] REMAIN_RESET  = 14'h0000;
	localparam logic [16:0] TOTAL_RESET   = 17'h0_0000;
endpackage : ohc_pkg
